// ===== design/pll_divider_config.sv
// Purpose: Divider configuration bank of the frequency synthesizer with
//          the reference divider and the dual-modulus feedback divider.
// Assumes: Classic Wishbone slave, 32-bit data, one clock, synchronous
//          active-low reset; tick inputs are one-cycle pulses.
// Notes:   Feedback ratio is main * P + swallow while bypass is clear.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pll_divider_config_map.svh"

module pll_divider_config #(
	parameter int REF_W = `PDC_REF_W,
	parameter int SWALLOW_W = `PDC_SWALLOW_W,
	parameter int MAIN_W = `PDC_MAIN_W
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire pll_divider_config_pkg::wb_req_s wb_req_in,
	output var pll_divider_config_pkg::wb_rsp_s wb_rsp_out,
	input wire logic ref_tick_in,
	input wire logic prescaler_tick_in,
	output var pll_divider_config_pkg::div_out_s div_out
);

	localparam pll_divider_config_pkg::regs_s REGS_RESET = '{
		ref_divider_low: `PDC_RST_REF_LOW,
		ref_divider_high: `PDC_RST_REF_HIGH,
		swallow_count: `PDC_RST_SWALLOW,
		main_feedback_count_low: `PDC_RST_MAIN_LOW,
		main_feedback_count_high: `PDC_RST_MAIN_HIGH,
		divider_control: `PDC_RST_CONTROL
	};

	localparam pll_divider_config_pkg::state_s STATE_RESET = '{
		regs: REGS_RESET,
		ack: 1'b0,
		rdat: '0,
		ref_cnt: '0,
		swallow_cnt: '0,
		main_cnt: '0,
		ref_pulse: 1'b0,
		fb_pulse: 1'b0
	};

	// The register layout packs each ratio into whole bytes, and the
	// counters live in the shared state type, so no other width can be
	// served without changing both.
	if (REF_W != `PDC_REF_W ||
		REF_W != 8 + `PDC_REF_HIGH_W) begin : g_bad_ref_w
		$error("Reference width does not match its two registers.");
	end
	if (MAIN_W != `PDC_MAIN_W ||
		MAIN_W != 8 + `PDC_MAIN_HIGH_W) begin : g_bad_main_w
		$error("Main counter width does not match its two registers.");
	end
	if (SWALLOW_W != `PDC_SWALLOW_W ||
		SWALLOW_W > 8) begin : g_bad_swallow_w
		$error("Swallow count does not fit its register.");
	end

	pll_divider_config_pkg::state_s state_q;
	pll_divider_config_pkg::state_s state_d;

	logic [`PDC_IDX_W-1:0] bus_idx;
	logic bus_req;
	logic bus_write;
	logic [7:0] wr_byte;
	logic [REF_W-1:0] ref_ratio;
	logic [SWALLOW_W-1:0] swallow_ratio;
	logic [MAIN_W-1:0] main_ratio;
	logic [MAIN_W-1:0] main_last;
	logic [REF_W-1:0] ref_last;
	logic cp_mid;
	logic ref_hold;
	logic fb_hold;
	logic bypass;
	logic [7:0] status_byte;
	logic [7:0] rd_byte;

	assign bus_idx = wb_req_in.adr[`PDC_IDX_LSB +: `PDC_IDX_W];
	assign bus_req = wb_req_in.cyc & wb_req_in.stb;
	// Writes land at the edge where the master sees ack.
	assign bus_write = bus_req & wb_req_in.we & state_q.ack
		& wb_req_in.sel[0];
	assign wr_byte = wb_req_in.dat[7:0];

	assign ref_ratio = {
		state_q.regs.ref_divider_high[`PDC_REF_HIGH_W-1:0],
		state_q.regs.ref_divider_low
	};
	assign swallow_ratio =
		state_q.regs.swallow_count[`PDC_SWALLOW_W-1:0];
	assign main_ratio = {
		state_q.regs.main_feedback_count_high[`PDC_MAIN_HIGH_W-1:0],
		state_q.regs.main_feedback_count_low
	};

	assign cp_mid = state_q.regs.divider_control[`PDC_BIT_CP_MID];
	assign ref_hold = state_q.regs.divider_control[`PDC_BIT_REF_RST]
		| state_q.regs.divider_control[`PDC_BIT_ALL_RST];
	assign fb_hold = state_q.regs.divider_control[`PDC_BIT_FB_RST]
		| state_q.regs.divider_control[`PDC_BIT_ALL_RST];
	// Bypass is obeyed whatever the prescaler mode; a wrong pairing is
	// left to software to avoid.
	assign bypass = state_q.regs.divider_control[`PDC_BIT_BYPASS];

	// A ratio of zero cannot divide, so it is served as divide by one.
	assign ref_last = (ref_ratio == '0) ? '0 : ref_ratio - 1'b1;
	assign main_last = (bypass || main_ratio == '0) ?
		'0 : main_ratio - 1'b1;

	assign status_byte = {
		4'h0,
		div_out.modulus_select,
		bypass,
		fb_hold,
		ref_hold
	};

	always_comb begin
		rd_byte = 8'h00;
		case (bus_idx)
			`PDC_IDX_REF_LOW: begin
				rd_byte = state_q.regs.ref_divider_low;
			end
			`PDC_IDX_REF_HIGH: begin
				rd_byte = state_q.regs.ref_divider_high;
			end
			`PDC_IDX_SWALLOW: begin
				rd_byte = state_q.regs.swallow_count;
			end
			`PDC_IDX_MAIN_LOW: begin
				rd_byte = state_q.regs.main_feedback_count_low;
			end
			`PDC_IDX_MAIN_HIGH: begin
				rd_byte = state_q.regs.main_feedback_count_high;
			end
			`PDC_IDX_CONTROL: begin
				rd_byte = state_q.regs.divider_control;
			end
			`PDC_IDX_STATUS: begin
				rd_byte = status_byte;
			end
			`PDC_IDX_REF_CNT_LOW: begin
				rd_byte = state_q.ref_cnt[7:0];
			end
			`PDC_IDX_REF_CNT_HIGH: begin
				rd_byte = {2'h0, state_q.ref_cnt[`PDC_REF_W-1:8]};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		state_d.ref_pulse = 1'b0;
		state_d.fb_pulse = 1'b0;

		// Every access is answered, mapped or not, so a stray address
		// never stalls the bus.
		state_d.ack = bus_req & ~state_q.ack;
		if (bus_req && !state_q.ack) begin
			state_d.rdat = {24'h000000, rd_byte};
		end

		if (bus_write) begin
			case (bus_idx)
				`PDC_IDX_REF_LOW: begin
					state_d.regs.ref_divider_low = wr_byte;
				end
				`PDC_IDX_REF_HIGH: begin
					state_d.regs.ref_divider_high =
						{2'h0, wr_byte[`PDC_REF_HIGH_W-1:0]};
				end
				`PDC_IDX_SWALLOW: begin
					state_d.regs.swallow_count =
						{2'h0, wr_byte[`PDC_SWALLOW_W-1:0]};
				end
				`PDC_IDX_MAIN_LOW: begin
					state_d.regs.main_feedback_count_low = wr_byte;
				end
				`PDC_IDX_MAIN_HIGH: begin
					state_d.regs.main_feedback_count_high =
						{3'h0, wr_byte[`PDC_MAIN_HIGH_W-1:0]};
				end
				`PDC_IDX_CONTROL: begin
					state_d.regs.divider_control = wr_byte;
				end
				default: begin
					state_d.regs = state_q.regs;
				end
			endcase
		end

		if (ref_hold) begin
			state_d.ref_cnt = '0;
		end else if (ref_tick_in) begin
			if (state_q.ref_cnt >= ref_last) begin
				state_d.ref_cnt = '0;
				state_d.ref_pulse = 1'b1;
			end else begin
				state_d.ref_cnt = state_q.ref_cnt + 1'b1;
			end
		end

		if (fb_hold) begin
			state_d.swallow_cnt = '0;
			state_d.main_cnt = '0;
		end else if (prescaler_tick_in) begin
			if (state_q.main_cnt >= main_last) begin
				state_d.main_cnt = '0;
				state_d.swallow_cnt = '0;
				state_d.fb_pulse = 1'b1;
			end else begin
				state_d.main_cnt = state_q.main_cnt + 1'b1;
				if (state_q.swallow_cnt < swallow_ratio) begin
					state_d.swallow_cnt = state_q.swallow_cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state_q <= STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign wb_rsp_out.ack = state_q.ack;
	assign wb_rsp_out.dat = state_q.rdat;

	assign div_out.ref_div_pulse = state_q.ref_pulse;
	assign div_out.fb_div_pulse = state_q.fb_pulse;
	// The prescaler divides by P+1 until the swallow count is used up;
	// under bypass the swallow count plays no part.
	assign div_out.modulus_select = ~fb_hold & ~bypass
		& (state_q.swallow_cnt < swallow_ratio);
	assign div_out.charge_pump_output_mid = cp_mid;
	assign div_out.ref_counter_held = ref_hold;
	assign div_out.fb_counters_held = fb_hold;
	assign div_out.main_bypass = bypass;
	assign div_out.aux_control =
		state_q.regs.divider_control[`PDC_AUX_W-1:0];

endmodule
`default_nettype wire

// ===== include/pll_divider_config_map.svh
// Purpose: Offsets, field positions, reset values and widths of the
//          synthesizer divider configuration bank.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Definitions only.
`ifndef PLL_DIVIDER_CONFIG_MAP_SVH
`define PLL_DIVIDER_CONFIG_MAP_SVH

`define PDC_ADR_W 8
`define PDC_DAT_W 32
`define PDC_SEL_W 4
`define PDC_IDX_W 6
`define PDC_IDX_LSB 2

`define PDC_IDX_REF_LOW 6'h11
`define PDC_IDX_REF_HIGH 6'h12
`define PDC_IDX_SWALLOW 6'h13
`define PDC_IDX_MAIN_LOW 6'h14
`define PDC_IDX_MAIN_HIGH 6'h15
`define PDC_IDX_CONTROL 6'h16
`define PDC_IDX_STATUS 6'h17
`define PDC_IDX_REF_CNT_LOW 6'h18
`define PDC_IDX_REF_CNT_HIGH 6'h19

`define PDC_RST_REF_LOW 8'h01
`define PDC_RST_REF_HIGH 8'h00
`define PDC_RST_SWALLOW 8'h00
`define PDC_RST_MAIN_LOW 8'h03
`define PDC_RST_MAIN_HIGH 8'h00
`define PDC_RST_CONTROL 8'h00

`define PDC_REF_W 14
`define PDC_SWALLOW_W 6
`define PDC_MAIN_W 13
`define PDC_REF_HIGH_W 6
`define PDC_MAIN_HIGH_W 5

`define PDC_BIT_CP_MID 7
`define PDC_BIT_REF_RST 6
`define PDC_BIT_FB_RST 5
`define PDC_BIT_ALL_RST 4
`define PDC_BIT_BYPASS 3
`define PDC_AUX_W 3

`endif

// ===== include/pll_divider_config_pkg.sv
// Purpose: Types shared by the divider configuration bank.
// Assumes: The constants header is on the include path.
// Notes:   Widths come from the constants header.
`include "pll_divider_config_map.svh"

package pll_divider_config_pkg;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`PDC_ADR_W-1:0] adr;
		logic [`PDC_SEL_W-1:0] sel;
		logic [`PDC_DAT_W-1:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic ack;
		logic [`PDC_DAT_W-1:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic [7:0] ref_divider_low;
		logic [7:0] ref_divider_high;
		logic [7:0] swallow_count;
		logic [7:0] main_feedback_count_low;
		logic [7:0] main_feedback_count_high;
		logic [7:0] divider_control;
	} regs_s;

	typedef struct packed {
		regs_s regs;
		logic ack;
		logic [`PDC_DAT_W-1:0] rdat;
		logic [`PDC_REF_W-1:0] ref_cnt;
		logic [`PDC_SWALLOW_W-1:0] swallow_cnt;
		logic [`PDC_MAIN_W-1:0] main_cnt;
		logic ref_pulse;
		logic fb_pulse;
	} state_s;

	typedef struct packed {
		logic ref_div_pulse;
		logic fb_div_pulse;
		logic modulus_select;
		logic charge_pump_output_mid;
		logic ref_counter_held;
		logic fb_counters_held;
		logic main_bypass;
		logic [`PDC_AUX_W-1:0] aux_control;
	} div_out_s;

endpackage

// ===== verification/pll_divider_config_monitor.sv
// Purpose: Bus and divider checks for the divider configuration bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Control bits are decoded from the write the bank acknowledges.
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config_monitor (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire pll_divider_config_pkg::wb_req_s wb_req_in,
	input wire pll_divider_config_pkg::wb_rsp_s wb_rsp_out,
	input wire logic ref_tick_in,
	input wire logic prescaler_tick_in,
	input wire pll_divider_config_pkg::div_out_s div_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic req = wb_req_in.cyc & wb_req_in.stb;
	wire logic wr_ctl = req & wb_rsp_out.ack & wb_req_in.we &
		wb_req_in.sel[0] & (wb_req_in.adr == 8'h58);
	wire logic [7:0] d = wb_req_in.dat[7:0];
	property p_ack_next;
		req && !wb_rsp_out.ack |=> wb_rsp_out.ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_rsp_out.ack |=> !wb_rsp_out.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck");
	property p_cp_mid;
		wr_ctl |=> div_out.charge_pump_output_mid == $past(d[7]);
	endproperty
	a_cp_mid: assert property (p_cp_mid) else $error("pump level");
	property p_ref_held;
		wr_ctl |=> div_out.ref_counter_held == $past(d[6] | d[4]);
	endproperty
	a_ref_held: assert property (p_ref_held) else $error("ref hold");
	property p_fb_held;
		wr_ctl |=> div_out.fb_counters_held == $past(d[5] | d[4]);
	endproperty
	a_fb_held: assert property (p_fb_held) else $error("fb hold");
	property p_bypass;
		wr_ctl |=> div_out.main_bypass == $past(d[3]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass bit");
	property p_ref_quiet;
		div_out.ref_counter_held [*2] |-> !div_out.ref_div_pulse;
	endproperty
	a_ref_quiet: assert property (p_ref_quiet) else $error("ref pulse");
	property p_fb_quiet;
		div_out.fb_counters_held [*2] |-> !div_out.fb_div_pulse;
	endproperty
	a_fb_quiet: assert property (p_fb_quiet) else $error("fb pulse");
	property p_by_every;
		div_out.main_bypass && !div_out.fb_counters_held &&
			prescaler_tick_in |=> div_out.fb_div_pulse;
	endproperty
	a_by_every: assert property (p_by_every) else $error("bypass");
endmodule
bind pll_divider_config pll_divider_config_monitor mon_u (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wb_req_in(wb_req_in),
	.wb_rsp_out(wb_rsp_out), .ref_tick_in(ref_tick_in),
	.prescaler_tick_in(prescaler_tick_in), .div_out(div_out));
`default_nettype wire

// ===== verification/test_pll_divider_config.sv
// Purpose: Self-checking bench for the divider configuration bank.
// Assumes: Bank answers each bus request one cycle after it is seen.
// Notes: Counters are cleared by a hold before each divider run.
`timescale 1ns/1ps
`default_nettype none
module test_pll_divider_config;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rt = 1'b0;
	logic pt = 1'b0;
	pll_divider_config_pkg::wb_req_s req = '0;
	pll_divider_config_pkg::wb_rsp_s rsp;
	pll_divider_config_pkg::div_out_s dv;
	int miscompares = 0;
	int cmp_count = 0;
	int nref;
	int nfb;
	logic [7:0] ex [6] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
	logic [7:0] mk [6] = '{8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'hFF};
	logic [7:0] r;
	logic [7:0] c;
	int rv;
	pll_divider_config dut_u (.sys_clk_in(clk), .rst_n_in(rst_n),
		.wb_req_in(req), .wb_rsp_out(rsp), .ref_tick_in(rt),
		.prescaler_tick_in(pt), .div_out(dv));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		nref += (dv.ref_div_pulse === 1'b1);
		nfb += (dv.fb_div_pulse === 1'b1);
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(logic w, logic [5:0] i, logic [7:0] d);
		int k;
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'h1, {24'h0, d}};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rsp.ack !== 1'b1);
		r = rsp.dat[7:0];
		chk("ack latency", 2, k);
		req <= '0;
	endtask
	task automatic run(int er, int ef);
		nref = 0;
		nfb = 0;
		repeat (12) @(posedge clk) begin
			rt <= 1'b1;
			pt <= 1'b1;
		end
		@(posedge clk) begin
			rt <= 1'b0;
			pt <= 1'b0;
		end
		repeat (3) @(posedge clk);
		chk("ref pulses", er, nref);
		chk("fb pulses", ef, nfb);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		conclude();
	end
	initial begin
		void'($urandom(75));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wb(0, 6'h11 + i, 8'h00);
			chk("reset", ex[i], r);
		end
		$display("test done: reset values");
		for (int i = 0; i < 6; i++) begin
			c = $urandom;
			wb(1, 6'h11 + i, c);
			ex[i] = c & mk[i];
			wb(0, 6'h11 + i, 8'h00);
			chk("readback", ex[i], r);
		end
		wb(1, 6'h30, 8'hFF);
		wb(0, 6'h30, 8'h00);
		chk("unmapped", 0, r);
		for (int i = 0; i < 6; i++) begin
			wb(0, 6'h11 + i, 8'h00);
			chk("model", ex[i], r);
		end
		$display("test done: readback");
		wb(1, 6'h13, 8'h00);
		for (int b = 0; b < 8; b++) begin
			c = 8'h01 << b;
			wb(1, 6'h16, c);
			@(posedge clk);
			chk("levels", {c[7], c[6] | c[4], c[5] | c[4], c[3], c[2:0]},
				dv[6:0]);
			wb(0, 6'h17, 8'h00);
			chk("status", {5'h00, c[3], c[5] | c[4], c[6] | c[4]}, r);
		end
		$display("test done: control levels");
		rv = 1 + $urandom % 4;
		wb(1, 6'h11, rv[7:0]);
		wb(1, 6'h12, 8'h00);
		wb(1, 6'h13, 8'h00);
		wb(1, 6'h14, 8'h03);
		wb(1, 6'h15, 8'h00);
		foreach (mk[j]) begin
			c = (j == 5) ? 8'h00 : (8'h80 >> j);
			if (j == 0) c = 8'h08;
			wb(1, 6'h16, 8'h10);
			wb(1, 6'h16, c);
			run((c[6] | c[4]) ? 0 : 12 / rv,
				(c[5] | c[4]) ? 0 : (c[3] ? 12 : 4));
		end
		$display("test done: dividers");
		wb(1, 6'h16, 8'h10);
		wb(1, 6'h11, 8'h05);
		wb(1, 6'h13, 8'h02);
		wb(1, 6'h16, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			chk("modulus", k != 2, dv[7]);
			rt <= 1'b1;
			pt <= 1'b1;
			@(posedge clk);
			rt <= 1'b0;
			pt <= 1'b0;
		end
		wb(0, 6'h18, 8'h00);
		chk("ref count", 4, r);
		wb(0, 6'h19, 8'h00);
		chk("ref count high", 0, r);
		$display("test done: modulus");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wb(0, 6'h11, 8'h00);
		chk("reset again", 8'h01, r);
		wb(0, 6'h13, 8'h00);
		chk("reset again", 8'h00, r);
		$display("test done: second reset");
		conclude();
	end
endmodule
`default_nettype wire
